// ===== flash_status_pkg.sv
package flash_status_pkg;

    // serial command codes
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OP_READ_LO = 8'h05;
    localparam logic [7:0] OP_READ_HI = 8'h35;
    localparam logic [7:0] OP_WRITE_SR = 8'h01;
    localparam logic [7:0] OP_WRITE_HI = 8'h31;
    localparam logic [7:0] OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
    localparam logic [7:0] OP_BLOCK64_ERASE = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7A;

    // status_protect_word field positions
    localparam int BIT_BUSY = 0;
    localparam int BIT_LATCH = 1;
    localparam int BP_LSB = 2;
    localparam int BIT_MODE_LO = 7;
    localparam int BIT_MODE_HI = 8;
    localparam int BIT_QE = 9;
    localparam int BIT_HPF = 10;
    localparam int LOCK_LSB = 11;
    localparam int BIT_CMP = 14;
    localparam int BIT_SUS = 15;

    // reset values
    localparam logic [4:0] BP_RESET = 5'h00;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [2:0] LOCK_RESET = 3'h0;

    // protect-mode encodings {hi, lo}
    localparam logic [1:0] MODE_SOFTWARE = 2'h0;
    localparam logic [1:0] MODE_HARDWARE = 2'h1;
    localparam logic [1:0] MODE_POWER_LOCK = 2'h2;
    localparam logic [1:0] MODE_OTP = 2'h3;

    // array geometry and protected-region sizing (log2 of bytes)
    localparam int ARRAY_AW = 19;
    localparam logic [4:0] SHIFT_LARGE_BASE = 5'h0F;
    localparam logic [4:0] SHIFT_SMALL_BASE = 5'h0B;
    localparam logic [4:0] SHIFT_SMALL_MAX = 5'h0F;

    // program/erase engine request kinds
    localparam logic [2:0] PE_PROGRAM = 3'h0;
    localparam logic [2:0] PE_SECTOR = 3'h1;
    localparam logic [2:0] PE_BLOCK32 = 3'h2;
    localparam logic [2:0] PE_BLOCK64 = 3'h3;
    localparam logic [2:0] PE_CHIP = 3'h4;

    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int SR_WRITE_TIME_NS = 1000;
    localparam int SR_WRITE_CYCLES = (SR_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SR_TIMER_W = 12;

endpackage

// ===== pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [WIDTH-1:0] d_in,
    input wire logic [WIDTH-1:0] reset_val_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] stab_ff;

    // reset value is a tied constant at the instance
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            meta_ff <= reset_val_in;
            stab_ff <= reset_val_in;
        end else if (ce_in) begin
            meta_ff <= d_in;
            stab_ff <= meta_ff;
        end
    end

    assign q_out = stab_ff;
endmodule

// ===== flash_status_protect_register.sv
`timescale 1ns/100ps
// Contract
// [R1] busy reads 1 during program, erase or status write, else 0
// [R2] latch flag mirrors write latch; at 0 status writes, program, erase refused
// [R3] five block-protect bits default zero, changed only by status write
// [R4] program and sector/block erase into protected region are refused
// [R5] block-protect bits change only outside hardware-protected mode
// [R6] chip erase runs only when nothing is protected
// [R7] mode 00 ignores write-protect pin; status write allowed with latch set
// [R8] mode 01 with write-protect pin low blocks status writes; here quad-enable 1 overrides the pin and lets them through
// [R9] mode 01 with write-protect pin high allows status writes with latch set
// [R10] mode 10 blocks status writes until power cycle, which clears mode
// [R11] mode 11 blocks status writes permanently; special-order option; here rst_in returns the mode to 00
// [R12] quad-enable default 0 keeps pin roles; 1 makes them data lines
// [R13] host must not set quad-enable with protect/hold pins tied to rails
// [R14] high-performance flag mirrors high-performance mode, default 0
// [R15] three one-time lock bits default 0; set means security registers read-only
// [R16] each lock bit may be set alone by status write, never cleared; here rst_in clears all three
// [R17] complement bit default 0 combines with block-protect to pick area
// [R18] suspend flag set after program/erase suspend command
// [R19] suspend flag cleared by resume command and by power cycle
// [R20] latch set by enable; cleared by power-up, disable, status write, program, erase
// [R21] host writes to busy, latch, high-performance and suspend bits ignored
module flash_status_protect_register
    import flash_status_pkg::*;
#(
    parameter bit OTP_MODE_EN = 1'b1,
    parameter int SR_WRITE_CYC = SR_WRITE_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic spi_sclk_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_si_in,
    input wire logic wp_n_in,
    input wire logic engine_busy_in,
    input wire logic high_perf_mode_in,
    output logic spi_so_out,
    output logic spi_so_oe_out,
    output logic pe_start_out,
    output logic [2:0] pe_kind_out,
    output logic [23:0] pe_addr_out,
    output logic [7:0] prog_data_out,
    output logic prog_data_valid_out,
    output logic suspend_req_out,
    output logic resume_req_out,
    output logic cmd_refused_out,
    output logic quad_enable_out,
    output logic [2:0] security_lock_out,
    output logic [15:0] status_word_out
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_OPCODE = 4'b0010,
        ST_ARGS = 4'b0100,
        ST_READ = 4'b1000
    } link_state_t;

    logic s_sclk, s_cs_n, s_si, s_wp_n;
    logic sclk_d_ff, cs_n_d_ff;
    logic sclk_rise, sclk_fall, cs_start, cs_end;
    link_state_t state_ff;
    logic [2:0] bit_cnt_ff;
    logic [2:0] byte_cnt_ff;
    logic [6:0] shreg_ff;
    logic byte_done;
    logic [7:0] byte_val;
    logic [7:0] opcode_ff;
    logic [23:0] addr_ff;
    logic [7:0] data0_ff, data1_ff;
    logic [7:0] out_sr_ff;
    logic so_ff;
    logic [4:0] bp_ff;
    logic [1:0] mode_ff;
    logic qe_ff, cmp_ff, sus_ff, latch_ff;
    logic [2:0] lock_ff;
    logic [SR_TIMER_W-1:0] sr_timer_ff;
    logic busy;
    logic [15:0] status;
    logic exec, sr_unlocked, sr_cmd, sr_ok, pe_cmd, pe_ok, wr_lo_en, wr_hi_en;
    logic [7:0] wr_lo, wr_hi;
    logic [1:0] nxt_mode;
    logic [2:0] kind;
    logic prot_hit, none_protected;

    // host-domain pins; sclk lasts many core cycles
    pin_sync #(.WIDTH(4)) u_sync (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .d_in({spi_sclk_in, spi_cs_n_in, spi_si_in, wp_n_in}),
        .reset_val_in(4'h5),
        .q_out({s_sclk, s_cs_n, s_si, s_wp_n})
    );

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            sclk_d_ff <= 1'b0;
            cs_n_d_ff <= 1'b1;
        end else if (ce_in) begin
            sclk_d_ff <= s_sclk;
            cs_n_d_ff <= s_cs_n;
        end
    end

    assign sclk_rise = s_sclk & ~sclk_d_ff & ~s_cs_n;
    assign sclk_fall = ~s_sclk & sclk_d_ff & ~s_cs_n;
    assign cs_start = cs_n_d_ff & ~s_cs_n;
    assign cs_end = ~cs_n_d_ff & s_cs_n;
    assign byte_done = sclk_rise & (bit_cnt_ff == 3'h7);
    assign byte_val = {shreg_ff, s_si};

    // protected-region decode; complement inverts the area
    function automatic logic region_hit(input logic [4:0] bp, input logic cmp, input logic [23:0] a);
        logic [4:0] sh;
        logic [ARRAY_AW-1:0] mask;
        logic hit;
        sh = SHIFT_LARGE_BASE;
        mask = '0;
        if (bp[2:0] == 3'h0) begin
            hit = 1'b0;
        end else if ((!bp[4] && bp[2]) || (bp[4] && bp[2:0] == 3'h7)) begin
            hit = 1'b1;
        end else begin
            if (!bp[4]) begin
                sh = SHIFT_LARGE_BASE + {3'h0, bp[1:0]};
            end else if (bp[2]) begin
                sh = SHIFT_SMALL_MAX;
            end else begin
                sh = SHIFT_SMALL_BASE + {3'h0, bp[1:0]};
            end
            mask = ~(({{(ARRAY_AW-1){1'b0}}, 1'b1} << sh) - {{(ARRAY_AW-1){1'b0}}, 1'b1});
            hit = bp[3] ? ((a[ARRAY_AW-1:0] & mask) == '0) : ((a[ARRAY_AW-1:0] & mask) == mask);
        end
        return hit ^ cmp; // [R17]
    endfunction

    assign busy = engine_busy_in | (sr_timer_ff != '0); // [R1]
    assign status = {sus_ff, cmp_ff, lock_ff, high_perf_mode_in, qe_ff, mode_ff, bp_ff, latch_ff, busy}; // [R14]

    // link framing state
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state_ff <= ST_IDLE;
        end else if (ce_in) begin
            if (cs_end) begin
                state_ff <= ST_IDLE;
            end else if (cs_start) begin
                state_ff <= ST_OPCODE;
            end else begin
                case (state_ff)
                    ST_OPCODE: begin
                        if (byte_done) begin
                            state_ff <= (byte_val == OP_READ_LO || byte_val == OP_READ_HI) ? ST_READ : ST_ARGS;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // bit and byte capture
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            bit_cnt_ff <= 3'h0;
            byte_cnt_ff <= 3'h0;
            shreg_ff <= 7'h00;
            opcode_ff <= 8'h00;
            addr_ff <= 24'h000000;
            data0_ff <= 8'h00;
            data1_ff <= 8'h00;
        end else if (ce_in) begin
            if (cs_start) begin
                bit_cnt_ff <= 3'h0;
                byte_cnt_ff <= 3'h0;
            end else if (sclk_rise) begin
                shreg_ff <= byte_val[6:0];
                bit_cnt_ff <= bit_cnt_ff + 3'h1;
                if (byte_done) begin
                    // saturates: page data bytes all land at index 4
                    if (byte_cnt_ff != 3'h4) begin
                        byte_cnt_ff <= byte_cnt_ff + 3'h1;
                    end
                    case (byte_cnt_ff)
                        3'h0: opcode_ff <= byte_val;
                        3'h1: begin
                            addr_ff[23:16] <= byte_val;
                            data0_ff <= byte_val;
                        end
                        3'h2: begin
                            addr_ff[15:8] <= byte_val;
                            data1_ff <= byte_val;
                        end
                        3'h3: addr_ff[7:0] <= byte_val;
                        default: ;
                    endcase
                end
            end
        end
    end

    // page data is passed to the array engine as it arrives
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            prog_data_out <= 8'h00;
            prog_data_valid_out <= 1'b0;
        end else if (ce_in) begin
            prog_data_valid_out <= byte_done && state_ff == ST_ARGS && byte_cnt_ff == 3'h4 && opcode_ff == OP_PAGE_PROG;
            if (byte_done) begin
                prog_data_out <= byte_val;
            end
        end
    end

    // status read-out, continuous: each byte boundary reloads the current value
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            out_sr_ff <= 8'h00;
            so_ff <= 1'b0;
        end else if (ce_in) begin
            if (byte_done) begin
                if (state_ff == ST_OPCODE) begin
                    out_sr_ff <= (byte_val == OP_READ_HI) ? status[15:8] : status[7:0];
                end else begin
                    out_sr_ff <= (opcode_ff == OP_READ_HI) ? status[15:8] : status[7:0];
                end
            end else if (sclk_fall && state_ff == ST_READ) begin
                so_ff <= out_sr_ff[7];
                out_sr_ff <= {out_sr_ff[6:0], 1'b0};
            end
        end
    end

    assign spi_so_out = so_ff;
    assign spi_so_oe_out = (state_ff == ST_READ) && !s_cs_n;

    // commands act only when chip select rises on a byte boundary
    assign exec = cs_end && state_ff == ST_ARGS && bit_cnt_ff == 3'h0;

    always_comb begin
        case (mode_ff)
            MODE_SOFTWARE: sr_unlocked = 1'b1; // [R7]
            MODE_HARDWARE: sr_unlocked = qe_ff | s_wp_n; // [R8] [R9] [R12]
            MODE_POWER_LOCK: sr_unlocked = 1'b0; // [R10]
            default: sr_unlocked = 1'b0; // [R11]
        endcase
    end

    assign sr_cmd = (opcode_ff == OP_WRITE_SR || opcode_ff == OP_WRITE_HI) && byte_cnt_ff >= 3'h2;
    assign sr_ok = latch_ff & ~busy & sr_unlocked; // [R2] [R5]
    assign wr_lo_en = exec && sr_ok && opcode_ff == OP_WRITE_SR;
    assign wr_hi_en = exec && sr_ok && ((opcode_ff == OP_WRITE_SR && byte_cnt_ff >= 3'h3) || opcode_ff == OP_WRITE_HI);
    assign wr_lo = data0_ff;
    assign wr_hi = (opcode_ff == OP_WRITE_HI) ? data0_ff : data1_ff;

    always_comb begin
        nxt_mode = mode_ff;
        if (wr_lo_en) begin
            nxt_mode[0] = wr_lo[BIT_MODE_LO];
        end
        if (wr_hi_en) begin
            nxt_mode[1] = wr_hi[BIT_MODE_HI - 8];
        end
        // without the special-order option the permanent lock is not reachable
        if (!OTP_MODE_EN && nxt_mode == MODE_OTP) begin
            nxt_mode = mode_ff; // [R11]
        end
    end

    always_comb begin
        case (opcode_ff)
            OP_PAGE_PROG: kind = PE_PROGRAM;
            OP_SECTOR_ERASE: kind = PE_SECTOR;
            OP_BLOCK32_ERASE: kind = PE_BLOCK32;
            OP_BLOCK64_ERASE: kind = PE_BLOCK64;
            default: kind = PE_CHIP;
        endcase
    end

    assign prot_hit = region_hit(bp_ff, cmp_ff, addr_ff);
    assign none_protected = ~region_hit(bp_ff, cmp_ff, 24'h000000) & ~region_hit(bp_ff, cmp_ff, 24'h07FFFF);
    assign pe_cmd = ((opcode_ff == OP_PAGE_PROG || opcode_ff == OP_SECTOR_ERASE || opcode_ff == OP_BLOCK32_ERASE
                      || opcode_ff == OP_BLOCK64_ERASE) && byte_cnt_ff == 3'h4)
                  || ((opcode_ff == OP_CHIP_ERASE_A || opcode_ff == OP_CHIP_ERASE_B) && byte_cnt_ff == 3'h1);
    assign pe_ok = latch_ff && !busy && !sus_ff
                && ((kind == PE_CHIP) ? none_protected : !prot_hit); // [R2] [R4] [R6]

    // protection bits: only an accepted status write changes them
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            bp_ff <= BP_RESET;
            mode_ff <= MODE_RESET; // [R10]
            qe_ff <= 1'b0;
            cmp_ff <= 1'b0;
            lock_ff <= LOCK_RESET;
        end else if (ce_in) begin
            mode_ff <= nxt_mode;
            if (wr_lo_en) begin
                bp_ff <= wr_lo[BP_LSB +: 5]; // [R3]
            end
            if (wr_hi_en) begin
                qe_ff <= wr_hi[BIT_QE - 8]; // [R12]
                cmp_ff <= wr_hi[BIT_CMP - 8]; // [R17]
                lock_ff <= lock_ff | wr_hi[LOCK_LSB - 8 +: 3]; // [R15] [R16]
            end
        end
    end

    // status write busy time
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            sr_timer_ff <= '0;
        end else if (ce_in) begin
            if (exec && sr_cmd && sr_ok) begin
                sr_timer_ff <= SR_TIMER_W'(SR_WRITE_CYC); // [R1]
            end else if (sr_timer_ff != '0) begin
                sr_timer_ff <= sr_timer_ff - 1'b1;
            end
        end
    end

    // write latch; status flags never follow host data
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            latch_ff <= 1'b0; // [R20]
        end else if (ce_in && exec) begin
            if (opcode_ff == OP_LATCH_SET && byte_cnt_ff == 3'h1) begin
                latch_ff <= 1'b1; // [R20]
            end else if ((opcode_ff == OP_LATCH_CLEAR && byte_cnt_ff == 3'h1)
                      || (sr_cmd && sr_ok) || (pe_cmd && pe_ok)) begin
                latch_ff <= 1'b0; // [R20] [R21]
            end
        end
    end

    // suspend flag and engine suspend/resume requests
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            sus_ff <= 1'b0; // [R19]
            suspend_req_out <= 1'b0;
            resume_req_out <= 1'b0;
        end else if (ce_in) begin
            suspend_req_out <= 1'b0;
            resume_req_out <= 1'b0;
            if (exec && opcode_ff == OP_SUSPEND && byte_cnt_ff == 3'h1 && engine_busy_in && !sus_ff) begin
                sus_ff <= 1'b1; // [R18]
                suspend_req_out <= 1'b1;
            end else if (exec && opcode_ff == OP_RESUME && byte_cnt_ff == 3'h1 && sus_ff) begin
                sus_ff <= 1'b0; // [R19]
                resume_req_out <= 1'b1;
            end
        end
    end

    // engine start and refusal reporting
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            pe_start_out <= 1'b0;
            pe_kind_out <= PE_PROGRAM;
            pe_addr_out <= 24'h000000;
            cmd_refused_out <= 1'b0;
        end else if (ce_in) begin
            pe_start_out <= exec && pe_cmd && pe_ok;
            cmd_refused_out <= exec && ((pe_cmd && !pe_ok) || (sr_cmd && !sr_ok)); // [R2] [R4] [R6]
            if (exec && pe_cmd && pe_ok) begin
                pe_kind_out <= kind;
                pe_addr_out <= addr_ff;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            status_word_out <= 16'h0000;
        end else if (ce_in) begin
            status_word_out <= status;
        end
    end

    assign quad_enable_out = qe_ff; // [R12]
    assign security_lock_out = lock_ff; // [R15]
endmodule

// ===== flash_host_model.sv
`timescale 1ns/100ps
module flash_host_model (
    input wire logic spi_so_in,
    output logic spi_sclk_out,
    output logic spi_cs_n_out,
    output logic spi_si_out
);
    initial begin
        spi_sclk_out = 1'b0;
        spi_cs_n_out = 1'b1;
        spi_si_out = 1'b0;
    end
    // mode 0: si moves while sclk is low; sclk idles low
    task automatic frame(input logic [39:0] bits, input int n, output logic [7:0] rd);
        rd = 8'h00;
        spi_cs_n_out = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            spi_si_out = bits[i];
            #62.5;
            spi_sclk_out = 1'b1;
            rd = {rd[6:0], spi_so_in};
            #62.5;
            spi_sclk_out = 1'b0;
        end
        #62.5;
        spi_cs_n_out = 1'b1;
        // flip released si so a stale bit never reads as data
        spi_si_out = ~spi_si_out;
        #250;
    endtask
endmodule

// ===== flash_status_monitor.sv
`timescale 1ns/100ps
module flash_status_monitor
    import flash_status_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic wp_n_in,
    input wire logic engine_busy_in,
    input wire logic high_perf_mode_in,
    input wire logic pe_start_out,
    input wire logic suspend_req_out,
    input wire logic resume_req_out,
    input wire logic cmd_refused_out,
    input wire logic quad_enable_out,
    input wire logic [2:0] security_lock_out,
    input wire logic [15:0] status_word_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);
    property p_busy_follows;
        $rose(engine_busy_in) |-> ##[1:4] status_word_out[BIT_BUSY];
    endproperty
    a_busy_follows: assert property (p_busy_follows) else $error("busy late");
    property p_start_needs_latch;
        pe_start_out |-> $past(status_word_out[BIT_LATCH]);
    endproperty
    a_start_needs_latch: assert property (p_start_needs_latch) else $error("start without latch");
    property p_start_clears_latch;
        pe_start_out |-> ##[1:4] !status_word_out[BIT_LATCH];
    endproperty
    a_start_clears_latch: assert property (p_start_clears_latch) else $error("latch kept");
    property p_hpf_follows;
        $rose(high_perf_mode_in) |-> ##[1:4] status_word_out[BIT_HPF];
    endproperty
    a_hpf_follows: assert property (p_hpf_follows) else $error("hpf late");
    property p_suspend_sets;
        suspend_req_out |-> ##[1:4] status_word_out[BIT_SUS];
    endproperty
    a_suspend_sets: assert property (p_suspend_sets) else $error("sus not set");
    property p_resume_clears;
        resume_req_out |-> ##[1:4] !status_word_out[BIT_SUS];
    endproperty
    a_resume_clears: assert property (p_resume_clears) else $error("sus not cleared");
    property p_qe_shown;
        $rose(quad_enable_out) |-> ##[0:2] status_word_out[BIT_QE];
    endproperty
    a_qe_shown: assert property (p_qe_shown) else $error("qe not shown");
    property p_lock_sticky;
        ($past(security_lock_out) & ~security_lock_out) == 3'h0;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit cleared");
    property p_mode_hi_frozen;
        status_word_out[BIT_MODE_HI] |=> $stable(status_word_out[9:2]) && $stable(status_word_out[14:11]);
    endproperty
    a_mode_hi_frozen: assert property (p_mode_hi_frozen) else $error("locked word changed");
    property p_hw_frozen;
        status_word_out[8:7] == MODE_HARDWARE && !status_word_out[BIT_QE] && !wp_n_in && !$past(wp_n_in, 8)
            |=> $stable(status_word_out[9:2]);
    endproperty
    a_hw_frozen: assert property (p_hw_frozen) else $error("bits changed, pin low");
    c_start: cover property (pe_start_out);
    c_refused: cover property (cmd_refused_out);
    c_suspend: cover property (suspend_req_out);
endmodule
bind flash_status_protect_register flash_status_monitor mon_u (.*);

// ===== flash_status_protect_register_test.sv
`timescale 1ns/100ps
module flash_status_protect_register_test
    import flash_status_pkg::*;
;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic wp_n_in = 1'b1;
    logic engine_busy_in = 1'b0;
    logic high_perf_mode_in = 1'b0;
    logic spi_sclk_in, spi_cs_n_in, spi_si_in, spi_so_out, pe_start_out, prog_data_valid_out;
    logic suspend_req_out, resume_req_out, cmd_refused_out;
    logic [2:0] pe_kind_out, security_lock_out;
    logic [23:0] pe_addr_out;
    logic [7:0] prog_data_out;
    logic [15:0] status_word_out;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int starts, refusals, susps, resms, busy_cyc, datas;
    always #2 core_clk_in = ~core_clk_in;
    flash_host_model host_u (.spi_so_in(spi_so_out), .spi_sclk_out(spi_sclk_in), .spi_cs_n_out(spi_cs_n_in),
        .spi_si_out(spi_si_in));
    flash_status_protect_register #(.OTP_MODE_EN(1'b1), .SR_WRITE_CYC(5)) dut_u (
        .ce_in(1'b1), .spi_so_oe_out(), .quad_enable_out(), .*
    );
    always @(posedge core_clk_in) begin
        cycles++;
        if (pe_start_out === 1'b1) starts++;
        if (cmd_refused_out === 1'b1) refusals++;
        if (suspend_req_out === 1'b1) susps++;
        if (resume_req_out === 1'b1) resms++;
        if (prog_data_valid_out === 1'b1) datas++;
        if (status_word_out[BIT_BUSY] === 1'b1) busy_cyc++;
        // run needs about 51000 cycles
        if (cycles == 80000) begin
            fail_count++;
            results();
        end
    end
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check_val(input string what, input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic zero;
        starts = 0;
        refusals = 0;
        susps = 0;
        resms = 0;
        busy_cyc = 0;
        datas = 0;
    endtask
    task automatic do_reset;
        @(posedge core_clk_in);
        rst_in <= 1'b1;
        repeat (8) @(posedge core_clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge core_clk_in);
    endtask
    task automatic send(input logic [39:0] bits, input int n);
        logic [7:0] rd;
        host_u.frame(bits, n, rd);
    endtask
    task automatic check_sr(input logic [15:0] exp);
        logic [7:0] lo, hi;
        host_u.frame({24'h0, OP_READ_LO, 8'h00}, 16, lo);
        host_u.frame({24'h0, OP_READ_HI, 8'h00}, 16, hi);
        check_val("sr_serial", exp, {hi, lo});
        check_val("sr_port", exp, status_word_out);
    endtask
    task automatic status_write_cmd(input logic [7:0] lo, input logic [7:0] hi);
        send({32'h0, OP_LATCH_SET}, 8);
        send({16'h0, OP_WRITE_SR, lo, hi}, 24);
    endtask
    task automatic pe(input logic [7:0] op, input logic [23:0] addr);
        send({32'h0, OP_LATCH_SET}, 8);
        if (op == OP_PAGE_PROG)
            send({op, addr, 8'hA5}, 40);
        else if (op == OP_CHIP_ERASE_A || op == OP_CHIP_ERASE_B)
            send({32'h0, op}, 8);
        else
            send({8'h0, op, addr}, 32);
    endtask
    task automatic t_latch;
        zero();
        send({16'h0, OP_WRITE_SR, 8'h3C, 8'h00}, 24);
        check_val("refused_no_latch", 24'h1, refusals);
        check_sr(16'h0000);
        send({32'h0, OP_LATCH_SET}, 8);
        check_sr(16'h0002);
        send({32'h0, OP_LATCH_CLEAR}, 8);
        check_sr(16'h0000);
    endtask
    task automatic t_write;
        @(posedge core_clk_in);
        wp_n_in <= 1'b0;
        zero();
        status_write_cmd(8'h3F, 8'hC6);
        check_val("busy_seen", 24'h1, busy_cyc >= 5);
        check_sr(16'h423C);
        @(posedge core_clk_in);
        wp_n_in <= 1'b1;
    endtask
    task automatic t_lock;
        status_write_cmd(8'h00, 8'h08);
        check_sr(16'h0800);
        status_write_cmd(8'h00, 8'h10);
        check_val("locks", 24'h3, security_lock_out);
        send({32'h0, OP_LATCH_SET}, 8);
        send({24'h0, OP_WRITE_HI, 8'h00}, 16);
        check_sr(16'h1800);
    endtask
    task automatic t_protect;
        logic [7:0] ops[3] = '{OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK64_ERASE};
        status_write_cmd(8'h10, 8'h00);
        zero();
        foreach (ops[i]) pe(ops[i], 24'h000000);
        pe(OP_PAGE_PROG, 24'h000000);
        pe(OP_CHIP_ERASE_A, 24'h0);
        check_val("refused_all", 24'h5, refusals);
        status_write_cmd(8'h04, 8'h00);
        zero();
        pe(OP_SECTOR_ERASE, 24'h070000);
        pe(OP_CHIP_ERASE_B, 24'h0);
        pe(OP_SECTOR_ERASE, 24'h001000);
        check_val("refused_upper", 24'h2, refusals);
        check_val("kind_sector", PE_SECTOR, pe_kind_out);
        check_val("addr_sector", 24'h001000, pe_addr_out);
        status_write_cmd(8'h00, 8'h00);
        zero();
        pe(OP_CHIP_ERASE_B, 24'h0);
        check_val("kind_chip", PE_CHIP, pe_kind_out);
        pe(OP_BLOCK64_ERASE, 24'h070000);
        check_val("kind_block", PE_BLOCK64, pe_kind_out);
        pe(OP_PAGE_PROG, 24'h000123);
        check_val("prog_data", 24'hA5, prog_data_out);
        check_val("data_valid", 24'h1, datas);
        check_val("starts", 24'h3, starts);
        check_sr(16'h1800);
    endtask
    task automatic t_busy;
        @(posedge core_clk_in);
        engine_busy_in <= 1'b1;
        repeat (8) @(posedge core_clk_in);
        check_val("busy_port", 24'h1801, status_word_out);
        zero();
        pe(OP_SECTOR_ERASE, 24'h0);
        send({32'h0, OP_SUSPEND}, 8);
        check_sr(16'h9803);
        send({32'h0, OP_RESUME}, 8);
        check_sr(16'h1803);
        check_val("pulses", 24'h111, {refusals[3:0], susps[3:0], resms[3:0]});
        @(posedge core_clk_in);
        engine_busy_in <= 1'b0;
        send({32'h0, OP_LATCH_CLEAR}, 8);
        check_sr(16'h1800);
    endtask
    task automatic t_hwmode;
        status_write_cmd(8'h80, 8'h00);
        @(posedge core_clk_in);
        wp_n_in <= 1'b0;
        zero();
        status_write_cmd(8'h84, 8'h00);
        check_val("refused_wp", 24'h1, refusals);
        check_sr(16'h1882);
        @(posedge core_clk_in);
        wp_n_in <= 1'b1;
        status_write_cmd(8'h84, 8'h00);
        check_sr(16'h1884);
        @(posedge core_clk_in);
        high_perf_mode_in <= 1'b1;
        repeat (8) @(posedge core_clk_in);
        check_val("hpf_port", 24'h1C84, status_word_out);
        high_perf_mode_in <= 1'b0;
    endtask
    task automatic t_powerlock;
        status_write_cmd(8'h00, 8'h01);
        status_write_cmd(8'h00, 8'h00);
        check_sr(16'h1902);
        do_reset();
        check_sr(16'h0000);
        status_write_cmd(8'h80, 8'h01);
        status_write_cmd(8'h00, 8'h00);
        check_sr(16'h0182);
    endtask
    initial begin
        do_reset();
        t_latch();
        t_write();
        t_lock();
        t_protect();
        t_busy();
        t_hwmode();
        t_powerlock();
        results();
    end
endmodule
